// *** rtl/io_status_pkg.sv ***
// package for the input status and configuration register block
// assumes an AXI4-Lite master with 32-bit data and byte addresses
package io_status_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] STATUS_CFG_INDEX = 8'h04;
  localparam logic [11:0] STATUS_CFG_ADDR = 12'h010;
  localparam int ADDR_W = 12;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int VERSION_LSB = 24;
  localparam int FILTER_LSB = 20;
  localparam int REVISION_LSB = 16;
  localparam int QUIET_BIT = 15;
  localparam int CHAIN_POL_BIT = 13;
  localparam int REF_RES_BIT = 12;
  localparam int CLK_SRC_BIT = 11;
  localparam int TEMP_EN_BIT = 9;
  localparam int TEMP_LSB = 1;
  // -----------------------------------------------------------------
  // reset values and identity (identity values arbitrary)
  // -----------------------------------------------------------------
  localparam logic [1:0] FILTER_RESET = 2'h2;
  localparam logic CHAIN_POL_RESET = 1'b1;
  localparam logic TEMP_EN_RESET = 1'b1;
  localparam logic [7:0] VERSION_CODE = 8'hA5;
  localparam logic [2:0] REVISION_CODE = 3'h5;
  // -----------------------------------------------------------------
  // filter codes and timing
  // -----------------------------------------------------------------
  localparam logic [1:0] FILTER_10NS = 2'h2;
  localparam logic [1:0] FILTER_20NS = 2'h3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILT_SHORT_NS = 10;
  localparam int FILT_LONG_NS = 20;
  localparam logic [1:0] FILT_SHORT_CYC = 2'(FILT_SHORT_NS / CLK_PERIOD_NS);
  localparam logic [1:0] FILT_LONG_CYC = 2'(FILT_LONG_NS / CLK_PERIOD_NS);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/input_status_config_register.sv ***
// input status and configuration register with AXI4-Lite access
// assumes status inputs synchronous to clk; resetn is asynchronous
//
// Contract
// - top byte holds read-only version code
// - filter selector bits 21:20, reset 2
// - bit 15 reads quiescent state
// - UART mode drives data-out at bit 13
// - chain polarity bit resets to one
// - bit 12 reports reference resistor detected
// - bit 11 reports external clock source
// - bit 9 enables temperature converter, reset 1
// - bits 8:1 hold temperature code
`timescale 1ns/1ps
`default_nettype none
module input_status_config_register
  import io_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // device status
  input wire logic quiescent,
  input wire logic refResistorDetected,
  input wire logic externalClockFlag,
  input wire logic [7:0] temperatureCode,
  input wire logic interfaceSelectUart,
  input wire logic serialIn,
  // device outputs
  output logic serialDataOut,
  output logic tempConverterEnable,
  output logic serialInFiltered
);
  // -----------------------------------------------------------------
  // reset release
  // -----------------------------------------------------------------
  // assertion is immediate, release waits two edges so that no flop
  // leaves reset in the very edge at which resetn rises
  logic rstSync1_reg, rstn_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_reg <= 1'b0;
      rstn_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstn_reg <= rstSync1_reg;
    end
  end

  // -----------------------------------------------------------------
  // configuration fields
  // -----------------------------------------------------------------
  logic [1:0] filterSel_reg;
  logic chainPol_reg;
  logic tempEn_reg;
  logic awHeld_reg, wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  // write channel capture: address and data taken in either order
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire haveAw = awHeld_reg || awTake;
  wire haveW = wHeld_reg || wTake;
  wire [ADDR_W-1:0] curAw = awHeld_reg ? awAddr_reg : awaddr;
  wire [31:0] curW = wHeld_reg ? wData_reg : wdata;
  wire [3:0] curS = wHeld_reg ? wStrb_reg : wstrb;
  wire doWrite = haveAw && haveW && !bvalid;
  wire wrHit = doWrite && (curAw == STATUS_CFG_ADDR);
  // only lanes 1 and 2 hold writable bits; the rest are ignored
  wire lane1 = wrHit && curS[1];
  wire lane2 = wrHit && curS[2];
  // an unmapped write is still answered, but changes nothing
  wire [1:0] bresp_next = wrHit ? RESP_OKAY : RESP_SLVERR;

  always_ff @(posedge clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awHeld_reg <= haveAw && !doWrite;
      wHeld_reg <= haveW && !doWrite;
      if (awTake) awAddr_reg <= awaddr;
      if (wTake) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      awready <= !(haveAw) && !bvalid && !doWrite;
      wready <= !(haveW) && !bvalid && !doWrite;
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= bresp_next;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // writable fields; unassigned bits are not stored at all
  always_ff @(posedge clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      filterSel_reg <= FILTER_RESET;
      chainPol_reg <= CHAIN_POL_RESET;
      tempEn_reg <= TEMP_EN_RESET;
    end else begin
      if (lane2) filterSel_reg <= curW[FILTER_LSB +: 2];
      if (lane1) chainPol_reg <= curW[CHAIN_POL_BIT];
      if (lane1) tempEn_reg <= curW[TEMP_EN_BIT];
    end
  end

  // -----------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------
  // word assembly; every unlisted bit stays zero
  logic [31:0] readWord;
  always_comb begin
    readWord = '0;
    readWord[VERSION_LSB +: 8] = VERSION_CODE;
    readWord[FILTER_LSB +: 2] = filterSel_reg;
    readWord[REVISION_LSB +: 3] = REVISION_CODE;
    readWord[QUIET_BIT] = quiescent;
    readWord[CHAIN_POL_BIT] = chainPol_reg;
    readWord[REF_RES_BIT] = refResistorDetected;
    readWord[CLK_SRC_BIT] = externalClockFlag;
    readWord[TEMP_EN_BIT] = tempEn_reg;
    readWord[TEMP_LSB +: 8] = temperatureCode;
  end
  wire rdHit = araddr == STATUS_CFG_ADDR;
  wire arTake = arvalid && arready;
  // status bits are a snapshot taken when the address is accepted;
  // unmapped reads give zero and an error rather than a mirror, so
  // software that scans the map sees holes as holes
  wire [31:0] rdata_next = rdHit ? readWord : '0;
  wire [1:0] rresp_next = rdHit ? RESP_OKAY : RESP_SLVERR;

  // one read at a time: arready drops while the answer stands
  always_ff @(posedge clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !arTake;
      if (arTake) begin
        rvalid <= 1'b1;
        rdata <= rdata_next;
        rresp <= rresp_next;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // serial input glitch filter and pin outputs
  // -----------------------------------------------------------------
  // a change must persist for the selected time before it passes;
  // codes 0 and 1 pass the input straight through one flop
  logic [1:0] stable_reg;
  logic lastIn_reg;
  wire [1:0] need = (filterSel_reg == FILTER_20NS) ? FILT_LONG_CYC :
                    (filterSel_reg == FILTER_10NS) ? FILT_SHORT_CYC : 2'h0;
  wire sameIn = serialIn == lastIn_reg;
  // run length saturates so a long quiet line cannot wrap and re-trigger
  wire [1:0] stable_next = !sameIn ? 2'h0 :
                           (stable_reg == 2'h3) ? stable_reg :
                           stable_reg + 2'h1;
  wire filterOff = need == 2'h0;
  wire filterPass = sameIn && (stable_reg >= need - 2'h1);
  // outside UART mode the pin belongs to the serial unit outside
  wire serialDataOut_next = interfaceSelectUart ? chainPol_reg : 1'b0;
  always_ff @(posedge clk or negedge rstn_reg) begin
    if (!rstn_reg) begin
      lastIn_reg <= 1'b0;
      stable_reg <= 2'h0;
      serialInFiltered <= 1'b0;
      serialDataOut <= 1'b0;
      tempConverterEnable <= 1'b0;
    end else begin
      lastIn_reg <= serialIn;
      stable_reg <= stable_next;
      if (filterOff) serialInFiltered <= serialIn;
      else if (filterPass) serialInFiltered <= lastIn_reg;
      serialDataOut <= serialDataOut_next;
      tempConverterEnable <= tempEn_reg;
    end
  end
endmodule
`default_nettype wire

// *** dv/input_status_config_register_sva.sv ***
// checker of the status register block, read side and pins
// assumes it is bound to the top ports of the block
`timescale 1ns/1ps
`default_nettype none
module input_status_config_register_sva
  import io_status_pkg::*;
(
  // read channel
  input wire logic clk, resetn, arvalid, arready, rvalid, rready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // pins
  input wire logic interfaceSelectUart, serialIn, serialDataOut,
  input wire logic tempConverterEnable, serialInFiltered
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // a good read word is judged at the edge that hands it over
  wire logic okRd = rvalid && rready && !rresp[1];
  ver_code_a: assert property (okRd |->
    rdata[31:24] == VERSION_CODE) else $error("version code wrong");
  spare_zero_a: assert property (rvalid |->
    {rdata[23:22], rdata[19], rdata[14], rdata[10], rdata[0]} == 6'h0)
    else $error("spare bit set");
  bad_addr_a: assert property (arvalid && arready &&
    araddr != STATUS_CFG_ADDR |=> rvalid && rresp == RESP_SLVERR &&
    rdata == 32'h0) else $error("unmapped read not refused");
  good_addr_a: assert property (arvalid && arready &&
    araddr == STATUS_CFG_ADDR |=> rvalid && rresp == RESP_OKAY)
    else $error("mapped read late or refused");
  chain_spi_a: assert property (!$past(interfaceSelectUart) |->
    !serialDataOut) else $error("data out driven outside uart");
  chain_uart_a: assert property (okRd && $past(interfaceSelectUart) |->
    serialDataOut == rdata[13]) else $error("data out level wrong");
  adc_pin_a: assert property (okRd |->
    tempConverterEnable == rdata[9]) else $error("converter pin wrong");
  filt_src_a: assert property ($rose(serialInFiltered) |->
    $past(serialIn)) else $error("filter rose without input");
endmodule
`default_nettype wire

// *** dv/input_status_config_register_test.sv ***
// bench for the status register block
// assumes package, block and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module input_status_config_register_test;
  import io_status_pkg::*;
  logic clk = 0, resetn = 0, serialIn = 0, awvalid = 0, wvalid = 0;
  logic bready = 0, arvalid = 0, rready = 0, quiescent = 0;
  logic refResistorDetected = 0, externalClockFlag = 0;
  logic interfaceSelectUart = 0, pol, en, seen, awready, wready, bvalid;
  logic arready, rvalid, serialDataOut, tempConverterEnable;
  logic serialInFiltered;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0, a;
  logic [31:0] wdata = '0, rdW, d, rdata;
  logic [7:0] temperatureCode = '0;
  logic [3:0] wstrb = '0, s;
  logic [1:0] fSel, rsp, wRsp, bresp, rresp;
  int checked = 0, nMismatch = 0;
  always #5 clk = ~clk;
  input_status_config_register uut (.clk, .resetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .quiescent, .refResistorDetected, .externalClockFlag, .temperatureCode,
    .interfaceSelectUart, .serialIn, .serialDataOut, .tempConverterEnable,
    .serialInFiltered);
  task automatic chk(input logic [31:0] sv, ev);
    checked++;
    if (sv !== ev) begin
      nMismatch++;
      $display("FAIL %0t seen %h expected %h", $time, sv, ev);
    end
  endtask
  // address and data offered together; byte lanes come from s
  task automatic wr(input logic [11:0] wa, input logic [31:0] wd);
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {wa, wd, s};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wRsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ra);
    @(posedge clk);
    araddr <= ra;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    {rdW, rsp} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  // expected word from the model fields and the live status inputs
  function automatic logic [31:0] expWord();
    return {VERSION_CODE, 2'h0, fSel, 1'b0, REVISION_CODE, quiescent, 1'b0,
      pol, refResistorDetected, externalClockFlag, 1'b0, en,
      temperatureCode, 1'b0};
  endfunction
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(29));
    {fSel, pol, en} = 4'hB;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(STATUS_CFG_ADDR);
    chk(rdW, expWord());
    // random settings and status; every fourth pass misses the map
    for (int i = 0; i < 24; i++) begin
      {quiescent, refResistorDetected, externalClockFlag, interfaceSelectUart,
        temperatureCode} <= 12'($urandom);
      a = i % 4 == 3 ? 12'h004 : STATUS_CFG_ADDR;
      {d, s} = {$urandom, 4'($urandom)};
      wr(a, d);
      chk(32'(wRsp), 32'(a == 12'h004 ? RESP_SLVERR : RESP_OKAY));
      if (a == STATUS_CFG_ADDR) {fSel, pol, en} =
        {s[2] ? d[21:20] : fSel, s[1] ? {d[13], d[9]} : {pol, en}};
      rd(a);
      chk(32'(rsp), 32'(a == 12'h004 ? RESP_SLVERR : RESP_OKAY));
      chk(rdW, a == 12'h004 ? 32'h0 : expWord());
      rd(STATUS_CFG_ADDR);
      chk(rdW, expWord());
      chk(32'(tempConverterEnable), 32'(en));
      chk(32'(serialDataOut), 32'(interfaceSelectUart & pol));
    end
    // pulses of one to three cycles against each filter code
    s = 4'h4;
    for (int f = 0; f < 4; f++) begin
      wr(STATUS_CFG_ADDR, 32'(f) << 20);
      for (int w = 1; w < 4; w++) begin
        seen = 1'b0;
        repeat (w) @(posedge clk) serialIn <= 1'b1;
        @(posedge clk) serialIn <= 1'b0;
        repeat (6) @(posedge clk) seen |= serialInFiltered;
        chk(32'(seen), 32'(w >= (f < 2 ? 1 : f)));
      end
    end
    report_and_stop();
  end
  // the run needs some 350 cycles; a hang is cut well after that
  initial begin
    #100us;
    nMismatch++;
    report_and_stop();
  end
endmodule
bind input_status_config_register input_status_config_register_sva sva (
  .clk, .resetn, .arvalid, .arready, .rvalid, .rready, .araddr, .rdata,
  .rresp, .interfaceSelectUart, .serialIn, .serialDataOut,
  .tempConverterEnable, .serialInFiltered);
`default_nettype wire
